// ==== pru_host.sv ====
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host controller driving the tile from software registers.
// ----------------------------------------------------------------
module pru_host
  import pru_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  pru_if.host lnk,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq_out
);
  import pru_pkg::*;

  typedef enum logic [2:0] {PRU_H_IDLE, PRU_H_CLR, PRU_H_P, PRU_H_D, PRU_H_GO, PRU_H_WAIT} pru_h_t;

  typedef struct packed {
    logic [DATA_W-1:0] period;
    logic [DATA_W-1:0] duty;
    pru_h_t st;
    logic [7:0] flag;
    logic ptr_clr;
    logic push;
    logic [DATA_W-1:0] wd;
    logic load_wr;
    logic tag_clr;
    logic done;
    logic mask;
    logic [7:0] tag;
    logic [31:0] rdata;
    logic irq_out;
  } pru_host_st_t;

  pru_host_st_t s_q;
  pru_host_st_t s_d;

  // Register access and the update sequence.
  always_comb
  begin
    s_d = s_q;
    s_d.ptr_clr = 1'b0;
    s_d.push = 1'b0;
    s_d.load_wr = 1'b0;
    s_d.tag_clr = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (wr)
    begin
      case (addr)
        A_CMD_PERIOD: s_d.period = wdata;
        A_CMD_DUTY: s_d.duty = wdata;
        A_CMD_GO: if (s_q.st == PRU_H_IDLE) s_d.st = PRU_H_CLR;
        A_IRQ_MASK: s_d.mask = wdata[ST_DONE];
        default: s_d.mask = s_q.mask;
      endcase
    end
    if (rd)
    begin
      case (addr)
        A_CMD_PERIOD: s_d.rdata = s_q.period;
        A_CMD_DUTY: s_d.rdata = s_q.duty;
        A_STATUS: s_d.rdata = {30'h0000_0000, s_q.st != PRU_H_IDLE, s_q.done};
        A_IRQ_MASK: s_d.rdata = {31'h0000_0000, s_q.mask};
        A_TAG: s_d.rdata = {24'h00_0000, s_q.tag};
        default: s_d.rdata = 32'h0000_0000;
      endcase
      if (addr == A_STATUS)
      begin
        s_d.done = 1'b0;
      end
    end
    case (s_q.st)
      PRU_H_IDLE:
      begin
        s_d.st = s_d.st;
      end
      PRU_H_CLR:
      begin
        s_d.load_wr = 1'b1;
        s_d.wd = s_q.period;
        s_d.ptr_clr = 1'b1;
        s_d.st = PRU_H_P;
      end
      PRU_H_P:
      begin
        s_d.push = 1'b1;
        s_d.wd = s_q.period;
        s_d.st = PRU_H_D;
      end
      PRU_H_D:
      begin
        s_d.push = 1'b1;
        s_d.wd = s_q.duty;
        s_d.st = PRU_H_GO;
      end
      PRU_H_GO:
      begin
        s_d.flag = REQ_MASK;
        s_d.st = PRU_H_WAIT;
      end
      PRU_H_WAIT:
      begin
        if (lnk.irq && !s_q.tag_clr)
        begin
          s_d.tag = lnk.irq_tag;
          s_d.tag_clr = 1'b1;
          if (lnk.irq_tag == TAG_DONE)
          begin
            s_d.flag = 8'h00;
            s_d.done = 1'b1;
            s_d.st = PRU_H_IDLE;
          end
        end
      end
      default:
      begin
        s_d.st = PRU_H_IDLE;
      end
    endcase
    s_d.irq_out = s_d.done & s_d.mask;
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.st <= PRU_H_IDLE;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign lnk.host_flag_register = s_q.flag;
  assign lnk.fifo_ptr_clr = s_q.ptr_clr;
  assign lnk.fifo_push = s_q.push;
  assign lnk.fifo_wdata = s_q.wd;
  assign lnk.load_wr = s_q.load_wr;
  assign lnk.load_wdata = s_q.wd;
  assign lnk.tag_clr = s_q.tag_clr;
  assign rdata = s_q.rdata;
  assign irq_out = s_q.irq_out;
endmodule

// ==== pru_pkg.sv ====
// Operation
// - Reload sets period, match1 sets duty
// - Changes apply at next counter-zero event
// - Four-entry FIFO, drained in insertion order
// - Host pushes period first, duty second
// - Request flag is flag register bit 2
// - Sequencer runs once per trigger rising edge
// - Trigger is counter-zero AND request flag
// - First pull loads counter active count
// - Duty pulled into work_reg1, then match1
// - Only move ops write match values
// - Last op raises interrupt, tag 1
// - Host acts only on tag 1
// - Host clears request bit after interrupt
// - Host writes reload before setting request
// - Direct writes best at counter-zero
// - Output low at zero, high at match1
// - Counter reloads 4000, match1 2000 default
package pru_pkg;

  // ------------------------------------------------------------
  // Widths and defaults.
  // ------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam logic [DATA_W-1:0] LOAD_RESET = 32'h0000_0fa0;
  localparam logic [DATA_W-1:0] MATCH1_RESET = 32'h0000_07d0;
  localparam logic [DATA_W-1:0] MATCH2_RESET = 32'h0000_0000;
  localparam int REQ_BIT = 2;
  localparam logic [7:0] REQ_MASK = 8'h04;
  localparam logic [7:0] TAG_DONE = 8'h01;

  // ------------------------------------------------------------
  // Host register map, word addresses.
  // ------------------------------------------------------------
  localparam logic [3:0] A_CMD_PERIOD = 4'h0;
  localparam logic [3:0] A_CMD_DUTY = 4'h1;
  localparam logic [3:0] A_CMD_GO = 4'h2;
  localparam logic [3:0] A_STATUS = 4'h3;
  localparam logic [3:0] A_IRQ_MASK = 4'h4;
  localparam logic [3:0] A_TAG = 4'h5;
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;

  // Sequencer steps.
  typedef enum logic [2:0] {PRU_SEQ_IDLE, PRU_SEQ_PULL_C, PRU_SEQ_PULL_R1, PRU_SEQ_MOVE_TO_MATCH1_OP, PRU_SEQ_IRQ} pru_seq_t;

endpackage

// ==== pru_if.sv ====
`timescale 1ns/100ps
// Link between the host controller and the PWM tile.
interface pru_if;
  import pru_pkg::*;
  logic [7:0] host_flag_register;
  logic fifo_ptr_clr;
  logic fifo_push;
  logic [DATA_W-1:0] fifo_wdata;
  logic load_wr;
  logic [DATA_W-1:0] load_wdata;
  logic irq;
  logic [7:0] irq_tag;
  logic tag_clr;
  modport device (input host_flag_register, fifo_ptr_clr, fifo_push, fifo_wdata, load_wr, load_wdata, tag_clr,
                  output irq, irq_tag);
  modport host (output host_flag_register, fifo_ptr_clr, fifo_push, fifo_wdata, load_wr, load_wdata, tag_clr,
                input irq, irq_tag);
endinterface

// ==== pru_counter.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Down counter and PWM state cell.
// ----------------------------------------------------------------
module pru_counter
  import pru_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic load_wr,
  input wire logic [pru_pkg::DATA_W-1:0] load_wdata,
  input wire logic cnt_wr,
  input wire logic [pru_pkg::DATA_W-1:0] cnt_wdata,
  input wire logic m1_wr,
  input wire logic m2_wr,
  input wire logic [pru_pkg::DATA_W-1:0] m_wdata,
  output logic count_zero,
  output logic pwm_out
);
  import pru_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] load;
    logic [DATA_W-1:0] cnt;
    logic [DATA_W-1:0] duty_match_value;
    logic [DATA_W-1:0] second_match_value;
    logic zero;
    logic pwm_state_cell;
  } pru_cnt_st_t;

  pru_cnt_st_t s_q;
  pru_cnt_st_t s_d;

  // Count down; the zero event reloads the count from the load value.
  always_comb
  begin
    s_d = s_q;
    s_d.zero = (s_q.cnt == '0);
    if (s_q.cnt == '0)
    begin
      s_d.cnt = s_q.load;
    end
    else
    begin
      s_d.cnt = s_q.cnt - 32'h0000_0001;
    end
    // The state cell clears on zero and sets on match1.
    if (s_q.cnt == '0)
    begin
      s_d.pwm_state_cell = 1'b0;
    end
    else if (s_q.cnt == s_q.duty_match_value)
    begin
      s_d.pwm_state_cell = 1'b1;
    end
    if (load_wr)
    begin
      s_d.load = load_wdata;
    end
    if (cnt_wr)
    begin
      s_d.cnt = cnt_wdata;
    end
    if (m1_wr)
    begin
      s_d.duty_match_value = m_wdata;
    end
    if (m2_wr)
    begin
      s_d.second_match_value = m_wdata;
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '{LOAD_RESET, LOAD_RESET, MATCH1_RESET, MATCH2_RESET, 1'b0, 1'b0};
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign count_zero = s_q.zero;
  assign pwm_out = s_q.pwm_state_cell;
endmodule

// ==== pru_device.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// PWM tile with FIFO and event sequencer.
// ----------------------------------------------------------------
module pru_device
  import pru_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  pru_if.device lnk,
  output logic pwm
);
  import pru_pkg::*;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [3:0][DATA_W-1:0] work;
    pru_seq_t seq;
    logic trig_prev;
    logic irq;
    logic [7:0] tag;
    logic pwm;
  } pru_dev_st_t;

  pru_dev_st_t s_q;
  pru_dev_st_t s_d;
  logic count_zero;
  logic pwm_raw;
  logic sequencer_trigger0;
  logic cnt_wr;
  logic m1_wr;

  // Request gate: counter-zero AND the request flag bit.
  assign sequencer_trigger0 = count_zero & lnk.host_flag_register[REQ_BIT];

  // Counter writes issued by the sequencer steps.
  assign cnt_wr = (s_q.seq == PRU_SEQ_PULL_C);
  assign m1_wr = (s_q.seq == PRU_SEQ_MOVE_TO_MATCH1_OP);

  pru_counter u_cnt (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .load_wr(lnk.load_wr),
    .load_wdata(lnk.load_wdata),
    .cnt_wr(cnt_wr),
    .cnt_wdata(s_q.mem[s_q.rptr]),
    .m1_wr(m1_wr),
    .m2_wr(1'b0),
    .m_wdata(s_q.work[1]),
    .count_zero(count_zero),
    .pwm_out(pwm_raw)
  );

  // FIFO, sequencer and interrupt logic.
  always_comb
  begin
    s_d = s_q;
    s_d.trig_prev = sequencer_trigger0;
    s_d.pwm = pwm_raw;
    if (lnk.fifo_ptr_clr)
    begin
      s_d.wptr = '0;
      s_d.rptr = '0;
    end
    else if (lnk.fifo_push)
    begin
      s_d.mem[s_q.wptr] = lnk.fifo_wdata;
      s_d.wptr = s_q.wptr + 2'h1;
    end
    if (lnk.tag_clr)
    begin
      s_d.irq = 1'b0;
    end
    case (s_q.seq)
      PRU_SEQ_IDLE:
      begin
        if (sequencer_trigger0 && !s_q.trig_prev)
        begin
          s_d.seq = PRU_SEQ_PULL_C;
        end
      end
      PRU_SEQ_PULL_C:
      begin
        s_d.rptr = s_q.rptr + 2'h1;
        s_d.seq = PRU_SEQ_PULL_R1;
      end
      PRU_SEQ_PULL_R1:
      begin
        s_d.work[1] = s_q.mem[s_q.rptr];
        s_d.rptr = s_q.rptr + 2'h1;
        s_d.seq = PRU_SEQ_MOVE_TO_MATCH1_OP;
      end
      PRU_SEQ_MOVE_TO_MATCH1_OP:
      begin
        s_d.seq = PRU_SEQ_IRQ;
      end
      PRU_SEQ_IRQ:
      begin
        s_d.irq = 1'b1;
        s_d.tag = TAG_DONE;
        s_d.seq = PRU_SEQ_IDLE;
      end
      default:
      begin
        s_d.seq = PRU_SEQ_IDLE;
      end
    endcase
  end

  // State register; working registers start at zero.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.seq <= PRU_SEQ_IDLE;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign lnk.irq = s_q.irq;
  assign lnk.irq_tag = s_q.tag;
  assign pwm = s_q.pwm;
endmodule

// ==== pru_sva.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Link checker between host and tile.
// ------------------------------------------------------------
module pru_sva
  import pru_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] host_flag_register,
  input wire logic fifo_ptr_clr,
  input wire logic fifo_push,
  input wire logic load_wr,
  input wire logic irq,
  input wire logic [7:0] irq_tag,
  input wire logic tag_clr
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  logic load_seen_q;
  logic [15:0] wait_q;
  // Tracks a reload write since the last request and the wait for the interrupt.
  always_ff @(posedge clk)
  begin
    if (srst || host_flag_register[2])
      load_seen_q <= 1'b0;
    else if (load_wr)
      load_seen_q <= 1'b1;
    if (srst || !host_flag_register[2] || irq)
      wait_q <= 16'h0000;
    else
      wait_q <= wait_q + 16'h0001;
  end
  AST_TAG_VALUE: assert property (irq |-> irq_tag == TAG_DONE)
    else $error("irq tag is not the done value");
  AST_IRQ_HOLD: assert property (irq && !tag_clr |=> irq)
    else $error("irq dropped without tag clear");
  AST_IRQ_DROP: assert property (tag_clr |=> !irq)
    else $error("irq stayed after tag clear");
  AST_REQ_AT_IRQ: assert property ($rose(irq) |-> host_flag_register[2])
    else $error("irq without request flag");
  AST_REQ_CLEAR: assert property ($rose(irq) |-> ##[1:8] !host_flag_register[2])
    else $error("request flag not cleared after irq");
  AST_TWO_PUSHES: assert property ($rose(fifo_push) |=> fifo_push ##1 !fifo_push)
    else $error("push burst is not two entries");
  AST_CLR_THEN_PUSH: assert property (fifo_ptr_clr |=> fifo_push)
    else $error("pointer clear not followed by push");
  AST_LOAD_FIRST: assert property ($rose(host_flag_register[2]) |-> load_seen_q)
    else $error("request raised before reload write");
  AST_WAIT_BOUND: assert property (wait_q < 16'd8200)
    else $error("update not done at counter zero");
  AST_FLAG_BITS: assert property ((host_flag_register & ~REQ_MASK) == 8'h00)
    else $error("flag bit other than request set");
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Bench for host and tile joined by the link.
// ------------------------------------------------------------
module tb;
  import pru_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq_out;
  logic pwm;
  int fails = 0;
  int samples_checked = 0;
  int pushes = 0;
  pru_if lnk();
  // Clock of 10 ns.
  always #5 clk = ~clk;
  // Counts FIFO entries sent over the link.
  always @(posedge clk)
    if (lnk.fifo_push === 1'b1)
      pushes++;
  pru_device pru_device_inst (.clk(clk), .srst(srst), .ce(ce), .lnk(lnk), .pwm(pwm));
  pru_host pru_host_inst (.clk(clk), .srst(srst), .ce(ce), .lnk(lnk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq_out(irq_out));
  pru_sva pru_sva_inst (.clk(clk), .srst(srst), .host_flag_register(lnk.host_flag_register),
    .fifo_ptr_clr(lnk.fifo_ptr_clr), .fifo_push(lnk.fifo_push), .load_wr(lnk.load_wr), .irq(lnk.irq),
    .irq_tag(lnk.irq_tag), .tag_clr(lnk.tag_clr));
  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task wait_lvl(input logic l, output int c);
    c = 0;
    while (pwm !== l && c < 9000)
    begin
      @(posedge clk);
      c++;
    end
  endtask
  // Measures one high time and one full period of the PWM output.
  task measure(output int hi, output int per);
    int n;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, n);
    per = hi + n;
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task t_default;
    int hi;
    int per;
    logic [31:0] v;
    rd_reg(A_STATUS, v);
    chk(v, 32'h0000_0000, "status after reset");
    rd_reg(4'hf, v);
    chk(v, 32'h0000_0000, "unmapped read");
    measure(hi, per);
    chk(hi, MATCH1_RESET, "default high time");
    chk(per, LOAD_RESET + 1, "default period");
    $display("t_default done");
  endtask
  // Holds the clock enable low for longer than a period; nothing may move, then the waveform resumes.
  task t_freeze;
    int hi;
    int per;
    logic l;
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    l = pwm;
    repeat (5000) @(posedge clk);
    chk(pwm, l, "pwm frozen by clock enable");
    chk(lnk.irq, 1'b0, "no interrupt while frozen");
    ce <= 1'b1;
    measure(hi, per);
    chk(hi, MATCH1_RESET, "high time after freeze");
    chk(per, LOAD_RESET + 1, "period after freeze");
    $display("t_freeze done");
  endtask
  task t_update(input logic [31:0] p, input logic [31:0] d, input logic [31:0] mask);
    int hi;
    int per;
    int n;
    int base;
    logic [31:0] v;
    base = pushes;
    wr_reg(A_IRQ_MASK, mask);
    wr_reg(A_CMD_PERIOD, p);
    wr_reg(A_CMD_DUTY, d);
    wr_reg(A_CMD_GO, 32'h0000_0000);
    wr_reg(A_CMD_GO, 32'h0000_0000);
    n = 0;
    while (lnk.irq !== 1'b1 && n < 9000)
    begin
      @(posedge clk);
      n++;
    end
    chk(lnk.irq_tag, TAG_DONE, "tag on link");
    repeat (4) @(posedge clk);
    chk(irq_out, mask[0], "irq output");
    rd_reg(A_TAG, v);
    chk(v, TAG_DONE, "tag register");
    rd_reg(A_STATUS, v);
    chk(v, 32'h0000_0001, "status done");
    rd_reg(A_STATUS, v);
    chk(v, 32'h0000_0000, "status cleared");
    chk(irq_out, 1'b0, "irq output cleared");
    chk(lnk.host_flag_register, 8'h00, "request flag cleared");
    measure(hi, per);
    chk(hi, d, "new high time");
    chk(per, p + 1, "new period");
    chk(pushes - base, 2, "entries pushed");
    $display("t_update done");
  endtask
  // ------------------------------------------------------------
  // Verdict, watchdog and main sequence.
  // ------------------------------------------------------------
  task give_verdict;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    #600000;
    fails++;
    give_verdict;
  end
  // Runs the scenarios.
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_default;
    t_freeze;
    t_update(32'h0000_00c8, 32'h0000_0032, 32'h0000_0001);
    t_update(32'h0000_012c, 32'h0000_0064, 32'h0000_0000);
    give_verdict;
  end
endmodule
